// file: core/spc_pin_control.sv
// Design decisions made here: the Avalon-MM interface to the registers and the register offsets.
`default_nettype none

module spc_pin_control (
    input  wire logic        SYS_CLK,          // System clock, 20 MHz.
    input  wire logic        ARST_N,           // Asynchronous reset, active low.
    input  wire logic [3:0]  AVS_ADDRESS,      // Byte address.
    input  wire logic        AVS_READ,         // Read request.
    input  wire logic        AVS_WRITE,        // Write request.
    input  wire logic [3:0]  AVS_BYTEENABLE,   // Byte lanes.
    input  wire logic [31:0] AVS_WRITEDATA,    // Write data.
    output logic      [31:0] AVS_READDATA,     // Read data.
    output logic             AVS_WAITREQUEST,  // Stall.
    input  wire logic [7:0]  PIN_IN,           // Pad levels.
    output logic      [7:0]  PIN_OUT,          // Pad drive levels.
    output logic      [7:0]  PIN_OE,           // Pad output enables.
    input  wire logic        RXD_IN,           // Dedicated receive pad.
    input  wire logic        QSPI_ACTIVE,      // Serial unit is transferring.
    input  wire logic [6:0]  QSPI_OUT,         // Serial unit pin drive.
    output logic      [6:0]  QSPI_IN,          // Pin levels to serial unit.
    input  wire logic        SCI_TXD,          // Transmitter data.
    output logic             SCI_RXD,          // Receive data to unit.
    output logic             SPI_ENABLE,       // SPI enable bit.
    output logic             MASTER_MODE,      // Master mode bit.
    output logic             TX_ENABLE,        // Transmitter enable bit.
    output logic             MODE_FAULT        // Sticky mode fault.
);

    // ==========================================================
    // Register state.
    // ==========================================================
    logic [7:0]  pin_assignment_reg;
    logic [7:0]  pin_direction_reg;
    logic [7:0]  port_data_latch_reg;
    logic        spi_enable_bit_reg;
    logic        master_mode_reg;
    logic        transmitter_enable_bit_reg;
    logic        mode_fault_reg;
    logic [31:0] readdata_reg;
    spc_pkg::spc_bus_state_type bus_state_reg;

    logic        wr_take;
    logic        rd_take;
    logic [31:0] readdata_next;
    logic [6:0]  owned;
    logic        fault_event;
    logic        fault_clear;

    // ==========================================================
    // Bus slave: each request answers on the second edge.
    // ==========================================================
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            bus_state_reg <= spc_pkg::BUS_IDLE;
        end else begin
            case (bus_state_reg)
                spc_pkg::BUS_IDLE: begin
                    if (AVS_READ || AVS_WRITE) begin
                        bus_state_reg <= spc_pkg::BUS_ANSWER;
                    end
                end
                spc_pkg::BUS_ANSWER: begin
                    bus_state_reg <= spc_pkg::BUS_IDLE;
                end
                default: begin
                    bus_state_reg <= spc_pkg::BUS_IDLE;
                end
            endcase
        end
    end

    assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && (bus_state_reg != spc_pkg::BUS_ANSWER);
    assign wr_take = AVS_WRITE && (bus_state_reg == spc_pkg::BUS_ANSWER);
    assign rd_take = AVS_READ && (bus_state_reg == spc_pkg::BUS_IDLE);

    always_comb begin
        readdata_next = spc_pkg::READ_ZERO;
        case (AVS_ADDRESS)
            spc_pkg::ADDR_PIN_CONFIG: begin
                readdata_next[spc_pkg::DIR_LSB +: 8]    = pin_direction_reg;
                readdata_next[spc_pkg::ASSIGN_LSB +: 8] = pin_assignment_reg;
            end
            spc_pkg::ADDR_PORT_DATA: begin
                readdata_next[7:0]              = PIN_IN;
                readdata_next[spc_pkg::RXD_BIT] = RXD_IN;
            end
            spc_pkg::ADDR_CONTROL: begin
                readdata_next[spc_pkg::CTRL_SPE]    = spi_enable_bit_reg;
                readdata_next[spc_pkg::CTRL_MASTER] = master_mode_reg;
                readdata_next[spc_pkg::CTRL_TE]     = transmitter_enable_bit_reg;
            end
            spc_pkg::ADDR_STATUS: begin
                readdata_next[spc_pkg::STAT_FAULT] = mode_fault_reg;
            end
            default: begin
                readdata_next = spc_pkg::READ_ZERO;
            end
        endcase
    end

    // Read data is captured while the stall is up, so it stands at the answer edge.
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            readdata_reg <= spc_pkg::READ_ZERO;
        end else if (rd_take) begin
            readdata_reg <= readdata_next;
        end
    end

    assign AVS_READDATA = readdata_reg;

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pin_assignment_reg <= spc_pkg::RESET_ASSIGN;
            pin_direction_reg  <= spc_pkg::RESET_DIR;
        end else if (wr_take && AVS_ADDRESS == spc_pkg::ADDR_PIN_CONFIG) begin
            if (AVS_BYTEENABLE[0]) begin
                pin_direction_reg <= AVS_WRITEDATA[spc_pkg::DIR_LSB +: 8];
            end
            if (AVS_BYTEENABLE[1]) begin
                pin_assignment_reg <= AVS_WRITEDATA[spc_pkg::ASSIGN_LSB +: 8];
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            port_data_latch_reg <= spc_pkg::RESET_PORT;
        end else if (wr_take && AVS_ADDRESS == spc_pkg::ADDR_PORT_DATA && AVS_BYTEENABLE[0]) begin
            port_data_latch_reg <= AVS_WRITEDATA[7:0];
        end
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            {transmitter_enable_bit_reg, master_mode_reg, spi_enable_bit_reg} <= spc_pkg::RESET_CTRL;
        end else if (wr_take && AVS_ADDRESS == spc_pkg::ADDR_CONTROL && AVS_BYTEENABLE[0]) begin
            spi_enable_bit_reg         <= AVS_WRITEDATA[spc_pkg::CTRL_SPE];
            master_mode_reg            <= AVS_WRITEDATA[spc_pkg::CTRL_MASTER];
            transmitter_enable_bit_reg <= AVS_WRITEDATA[spc_pkg::CTRL_TE];
        end
    end

    // ==========================================================
    // Pin ownership.
    // ==========================================================
    // master needs enable
    always_comb begin
        for (int i = 0; i < spc_pkg::QSPI_PINS; i++) begin
            owned[i] = pin_assignment_reg[i] && spi_enable_bit_reg;
        end
        if (!master_mode_reg && pin_assignment_reg[spc_pkg::MISO_PIN]) begin
            owned[spc_pkg::MISO_PIN] = 1'b1;
        end
    end

    always_comb begin
        QSPI_IN = PIN_IN[6:0] & owned;
        if (master_mode_reg && pin_direction_reg[spc_pkg::MISO_PIN]) begin
            QSPI_IN[spc_pkg::MISO_PIN] = 1'b0;
        end
    end

    assign SCI_RXD = RXD_IN;

    // ==========================================================
    // Mode fault: a low select input while master and enabled.
    // ==========================================================
    // select fault
    assign fault_event = master_mode_reg && owned[spc_pkg::SSEL_PIN]
                         && !pin_direction_reg[spc_pkg::SSEL_PIN] && !PIN_IN[spc_pkg::SSEL_PIN];
    assign fault_clear = wr_take && AVS_ADDRESS == spc_pkg::ADDR_STATUS
                         && AVS_BYTEENABLE[0] && AVS_WRITEDATA[spc_pkg::STAT_FAULT];

    // A fault in the same cycle as the clear survives, so no event is lost.
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            mode_fault_reg <= 1'b0;
        end else if (fault_event) begin
            mode_fault_reg <= 1'b1;
        end else if (fault_clear) begin
            mode_fault_reg <= 1'b0;
        end
    end

    assign MODE_FAULT  = mode_fault_reg;
    assign SPI_ENABLE  = spi_enable_bit_reg;
    assign MASTER_MODE = master_mode_reg;
    assign TX_ENABLE   = transmitter_enable_bit_reg;

    // ==========================================================
    // Pin cells.
    // ==========================================================
    // eight shared pins
    genvar g;
    generate
        for (g = 0; g < spc_pkg::PIN_COUNT; g++) begin : gen_pin
            if (g == spc_pkg::TXD_PIN) begin : gen_txd
                spc_pin_cell u_cell (
                    .clk       (SYS_CLK),
                    .arst_n    (ARST_N),
                    .owned     (1'b0),
                    .unit_out  (1'b0),
                    .port_bit  (port_data_latch_reg[g]),
                    .dir_bit   (pin_direction_reg[g]),
                    .force_en  (transmitter_enable_bit_reg),
                    .force_val (SCI_TXD),
                    .pin_out   (PIN_OUT[g]),
                    .pin_oe    (PIN_OE[g])
                );
            end else begin : gen_qspi
                spc_pin_cell u_cell (
                    .clk       (SYS_CLK),
                    .arst_n    (ARST_N),
                    .owned     (owned[g] && QSPI_ACTIVE),
                    .unit_out  (QSPI_OUT[g]),
                    .port_bit  (port_data_latch_reg[g]),
                    .dir_bit   (pin_direction_reg[g]),
                    .force_en  (1'b0),
                    .force_val (1'b0),
                    .pin_out   (PIN_OUT[g]),
                    .pin_oe    (PIN_OE[g])
                );
            end
        end
    endgenerate

    // ==========================================================
    // Assertions.
    // ==========================================================
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!ARST_N);

    property p_gpio_drive;
        !pin_assignment_reg[1] && !transmitter_enable_bit_reg ##1 1'b1
            |-> PIN_OUT[1] == $past(port_data_latch_reg[1]);
    endproperty
    a_gpio_drive: assert property (p_gpio_drive) else $error("gpio pin not driven from port data");

    property p_direction;
        ##1 PIN_OE[6:0] == $past(pin_direction_reg[6:0]);
    endproperty
    a_direction: assert property (p_direction) else $error("output enable differs from direction");

    property p_master_gate;
        master_mode_reg && !spi_enable_bit_reg |=> PIN_OUT[1] == $past(port_data_latch_reg[1]);
    endproperty
    a_master_gate: assert property (p_master_gate) else $error("pin owned without enable");

    property p_slave_miso;
        !master_mode_reg && pin_assignment_reg[0] && QSPI_ACTIVE |=> PIN_OUT[0] == $past(QSPI_OUT[0]);
    endproperty
    a_slave_miso: assert property (p_slave_miso) else $error("slave MISO not from serial unit");

    property p_txd_forced;
        transmitter_enable_bit_reg |=> PIN_OE[7] && PIN_OUT[7] == $past(SCI_TXD);
    endproperty
    a_txd_forced: assert property (p_txd_forced) else $error("transmit pin not forced");

    property p_txd_dir;
        !transmitter_enable_bit_reg |=> PIN_OE[7] == $past(pin_direction_reg[7]);
    endproperty
    a_txd_dir: assert property (p_txd_dir) else $error("transmit pin direction wrong");

    property p_port_write;
        wr_take && AVS_ADDRESS == spc_pkg::ADDR_PORT_DATA && AVS_BYTEENABLE[0]
            |=> port_data_latch_reg == $past(AVS_WRITEDATA[7:0]);
    endproperty
    a_port_write: assert property (p_port_write) else $error("port data write lost");

    property p_read_live;
        rd_take && AVS_ADDRESS == spc_pkg::ADDR_PORT_DATA |=> AVS_READDATA[7:0] == $past(PIN_IN);
    endproperty
    a_read_live: assert property (p_read_live) else $error("port read not live pins");

    property p_answer;
        AVS_READ && bus_state_reg == spc_pkg::BUS_IDLE |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST;
    endproperty
    a_answer: assert property (p_answer) else $error("read not answered on second edge");

    property p_fault;
        fault_event |=> mode_fault_reg;
    endproperty
    a_fault: assert property (p_fault) else $error("mode fault not raised");

    property p_fault_sticky;
        mode_fault_reg && !fault_clear |=> mode_fault_reg;
    endproperty
    a_fault_sticky: assert property (p_fault_sticky) else $error("mode fault dropped without clear");

    property p_miso_input;
        master_mode_reg && owned[spc_pkg::MISO_PIN] && !pin_direction_reg[spc_pkg::MISO_PIN]
            |-> QSPI_IN[spc_pkg::MISO_PIN] == PIN_IN[spc_pkg::MISO_PIN];
    endproperty
    a_miso_input: assert property (p_miso_input) else $error("MISO input not passed to serial unit");

    property p_inactive_port;
        !QSPI_ACTIVE |=> PIN_OUT[spc_pkg::SCK_PIN] == $past(port_data_latch_reg[spc_pkg::SCK_PIN]);
    endproperty
    a_inactive_port: assert property (p_inactive_port) else $error("idle serial pin not from port data");

    c_txd: cover property (transmitter_enable_bit_reg ##1 PIN_OE[7]);
    c_fault: cover property (fault_event ##1 fault_clear);
    c_qspi: cover property (QSPI_ACTIVE && owned[2] ##1 PIN_OUT[2]);

endmodule

`default_nettype wire

// file: pkg/spc_pkg.sv
`default_nettype none

package spc_pkg;

    // ==========================================================
    // Register map, byte addresses on the 32-bit slave port.
    // ==========================================================
    localparam logic [3:0] ADDR_PIN_CONFIG = 4'h0;
    localparam logic [3:0] ADDR_PORT_DATA  = 4'h4;
    localparam logic [3:0] ADDR_CONTROL    = 4'h8;
    localparam logic [3:0] ADDR_STATUS     = 4'hC;

    // ==========================================================
    // Widths and field positions.
    // ==========================================================
    localparam int PIN_COUNT   = 8;
    localparam int QSPI_PINS   = 7;
    localparam int DIR_LSB     = 0;
    localparam int ASSIGN_LSB  = 8;
    localparam int RXD_BIT     = 8;
    localparam int MISO_PIN    = 0;
    localparam int SCK_PIN     = 2;
    localparam int SSEL_PIN    = 3;
    localparam int TXD_PIN     = 7;
    localparam int CTRL_SPE    = 0;
    localparam int CTRL_MASTER = 1;
    localparam int CTRL_TE     = 2;
    localparam int STAT_FAULT  = 0;

    // ==========================================================
    // Reset values.
    // ==========================================================
    localparam logic [7:0]  RESET_ASSIGN = 8'h00;
    localparam logic [7:0]  RESET_DIR    = 8'h00;
    localparam logic [7:0]  RESET_PORT   = 8'h00;
    localparam logic [2:0]  RESET_CTRL   = 3'h0;
    localparam logic [31:0] READ_ZERO    = 32'h0000_0000;

    typedef enum logic [1:0] {
        BUS_IDLE   = 2'b00,
        BUS_ANSWER = 2'b01
    } spc_bus_state_type;

endpackage

`default_nettype wire

// file: core/spc_pin_cell.sv
`default_nettype none

module spc_pin_cell (
    input  wire logic clk,         // System clock.
    input  wire logic arst_n,      // Asynchronous reset, active low.
    input  wire logic owned,       // Pin is given to the serial unit.
    input  wire logic unit_out,    // Level the serial unit drives.
    input  wire logic port_bit,    // Latched port data bit.
    input  wire logic dir_bit,     // Direction bit, one is output.
    input  wire logic force_en,    // Transmitter takes the pin.
    input  wire logic force_val,   // Transmitter data.
    output logic      pin_out,     // Registered pin level.
    output logic      pin_oe       // Registered output enable.
);

    logic out_next;
    logic oe_next;

    always_comb begin
        if (force_en) begin
            out_next = force_val;
            oe_next  = 1'b1;
        end else begin
            out_next = owned ? unit_out : port_bit;
            oe_next  = dir_bit;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_out <= 1'b0;
            pin_oe  <= 1'b0;
        end else begin
            pin_out <= out_next;
            pin_oe  <= oe_next;
        end
    end

endmodule

`default_nettype wire

// file: verification/spc_partner.sv
`default_nettype none

module spc_partner (
    input  wire logic       clk,          // System clock.
    input  wire logic [7:0] ext_cmd,      // Level the outside world puts on each pad.
    input  wire logic       busy_cmd,     // Serial unit transferring.
    input  wire logic [6:0] drive_cmd,    // Serial unit pin drive.
    input  wire logic       txd_cmd,      // Transmitter data.
    input  wire logic       rxd_cmd,      // Receive pad level.
    input  wire logic [7:0] pin_out,      // Pad drive from the block.
    input  wire logic [7:0] pin_oe,       // Pad enables from the block.
    output logic      [7:0] pin_in,       // Resolved pad levels.
    output logic            qspi_active,  // Serial unit busy.
    output logic      [6:0] qspi_out,     // Serial unit drive.
    output logic            sci_txd,      // Transmitter data.
    output logic            rxd_in        // Receive pad.
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [7:0] ext_reg   = 8'h00;
    logic       busy_reg  = 1'h0;
    logic [6:0] drive_reg = 7'h00;
    logic       txd_reg   = 1'h0;
    logic       rxd_reg   = 1'h0;

    // ==========================================================
    // Serial units and outside world.
    // ==========================================================
    // The units launch just after the edge, as real flops would.
    always @(posedge clk) begin
        ext_reg   <= ext_cmd;
        busy_reg  <= busy_cmd;
        drive_reg <= drive_cmd;
        txd_reg   <= txd_cmd;
        rxd_reg   <= rxd_cmd;
    end

    // A pad the block drives shows the block's level; otherwise the outside level wins.
    assign pin_in      = (pin_oe & pin_out) | (~pin_oe & ext_reg);
    assign qspi_active = busy_reg;
    assign qspi_out    = drive_reg;
    assign sci_txd     = txd_reg;
    assign rxd_in      = rxd_reg;
endmodule

`default_nettype wire

// file: verification/spc_pin_control_tb_top.sv
`default_nettype none

module spc_pin_control_tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk, arst_n, rd_s, wr_s, wait_s, qact, txd, rxd, rxd_o, spi_enable_bit, mst, te, flt;
    logic [3:0]  addr, be;
    logic [31:0] wdata, rdata;
    logic [7:0]  pin_in, pin_out, pin_oe, ext_c;
    logic [6:0]  qout, qin, drive_c;
    logic        busy_c, txd_c, rxd_c;
    int          n_errors, total_checks;

    spc_pin_control u_spc_pin_control (.SYS_CLK(clk), .ARST_N(arst_n), .AVS_ADDRESS(addr), .AVS_READ(rd_s),
        .AVS_WRITE(wr_s), .AVS_BYTEENABLE(be), .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata),
        .AVS_WAITREQUEST(wait_s), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe), .RXD_IN(rxd),
        .QSPI_ACTIVE(qact), .QSPI_OUT(qout), .QSPI_IN(qin), .SCI_TXD(txd), .SCI_RXD(rxd_o),
        .SPI_ENABLE(spi_enable_bit), .MASTER_MODE(mst), .TX_ENABLE(te), .MODE_FAULT(flt));

    spc_partner u_spc_partner (.clk(clk), .ext_cmd(ext_c), .busy_cmd(busy_c), .drive_cmd(drive_c),
        .txd_cmd(txd_c), .rxd_cmd(rxd_c), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in),
        .qspi_active(qact), .qspi_out(qout), .sci_txd(txd), .rxd_in(rxd));

    // ==========================================================
    // Clock, counters and closing.
    // ==========================================================
    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end

    task automatic end_sim;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // ==========================================================
    // Bus and far-side helpers.
    // ==========================================================
    // The request is held until waitrequest is sampled low at a rising edge, then released at that edge.
    task automatic bus(input logic [3:0] a, input logic [3:0] b, input logic [31:0] d, input logic w,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        addr  <= a;
        be    <= b;
        wdata <= d;
        wr_s  <= w;
        rd_s  <= ~w;
        do begin
            @(posedge clk);
            n++;
        end while (wait_s !== 1'h0 && n < 20);
        if (n >= 20) chk("waitrequest", 32'h0000_0000, 32'h0000_0001);
        q = rdata;
        rd_s <= 1'h0;
        wr_s <= 1'h0;
    endtask

    task automatic wr(input logic [3:0] a, input logic [3:0] b, input logic [31:0] d);
        logic [31:0] q;
        bus(a, b, d, 1'h1, q);
    endtask

    task automatic rdc(input string what, input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(a, 4'hF, 32'h0000_0000, 1'h0, q);
        chk(what, exp, q);
    endtask

    task automatic far(input logic [7:0] e, input logic bsy, input logic [6:0] dv, input logic t);
        @(posedge clk);
        ext_c   <= e;
        busy_c  <= bsy;
        drive_c <= dv;
        txd_c   <= t;
    endtask

    // Two edges cover the partner's launch and the block's registered pads.
    task automatic settle;
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic pins(input logic [7:0] eo, input logic [7:0] ee);
        chk("pin_out", {24'h00_0000, eo}, {24'h00_0000, pin_out});
        chk("pin_oe", {24'h00_0000, ee}, {24'h00_0000, pin_oe});
    endtask

    initial begin
        #(50 * 4000);
        n_errors++;
        $display("ERROR watchdog expected done seen timeout");
        end_sim();
    end

    // ==========================================================
    // Tests.
    // ==========================================================
    initial begin
        n_errors = 0;
        total_checks = 0;
        {arst_n, rd_s, wr_s, addr, be, wdata} = '0;
        {ext_c, busy_c, drive_c, txd_c} = '0;
        rxd_c = 1'h1;
        repeat (8) @(posedge clk);
        arst_n <= 1'h1;
        rdc("config", 4'h0, 32'h0000_0000);
        rdc("control", 4'h8, 32'h0000_0000);
        settle();
        pins(8'h00, 8'h00);
        $display("test reset finished");

        wr(4'h0, 4'h2, 32'h0000_A500);
        wr(4'h0, 4'h1, 32'h0000_003C);
        wr(4'h2, 4'hF, 32'hFFFF_FFFF);
        rdc("unmapped", 4'h2, 32'h0000_0000);
        rdc("config", 4'h0, 32'h0000_A53C);
        settle();
        pins(8'h00, 8'h3C);
        wr(4'h0, 4'h3, 32'h0000_0000);
        $display("test registers finished");

        far(8'hC3, 1'h0, 7'h7F, 1'h0);
        wr(4'h4, 4'h1, 32'h0000_005A);
        wr(4'h0, 4'h1, 32'h0000_000F);
        settle();
        pins(8'h5A, 8'h0F);
        rdc("port", 4'h4, 32'h0000_01CA);
        chk("rxd", 32'h0000_0001, {31'h0000_0000, rxd_o});
        $display("test gpio finished");

        wr(4'h0, 4'h3, 32'h0000_070E);
        wr(4'h8, 4'h1, 32'h0000_0002);
        far(8'hC3, 1'h1, 7'h7F, 1'h0);
        settle();
        pins(8'h5A, 8'h0E);
        chk("qspi_in", 32'h0000_0000, {25'h000_0000, qin});
        wr(4'h8, 4'h1, 32'h0000_0003);
        settle();
        pins(8'h5F, 8'h0E);
        chk("qspi_in", 32'h0000_0007, {25'h000_0000, qin});
        chk("control_bits", 32'h0000_0003, {29'h0000_0000, te, mst, spi_enable_bit});
        rdc("control", 4'h8, 32'h0000_0003);
        far(8'hC3, 1'h0, 7'h7F, 1'h0);
        settle();
        pins(8'h5A, 8'h0E);
        $display("test master finished");

        wr(4'h8, 4'h1, 32'h0000_0000);
        wr(4'h0, 4'h1, 32'h0000_000F);
        far(8'hC3, 1'h1, 7'h7F, 1'h0);
        settle();
        pins(8'h5B, 8'h0F);
        $display("test slave finished");

        far(8'hC3, 1'h0, 7'h7F, 1'h1);
        wr(4'h0, 4'h3, 32'h0000_0000);
        wr(4'h8, 4'h1, 32'h0000_0004);
        settle();
        pins(8'hDA, 8'h80);
        chk("tx_enable", 32'h0000_0001, {31'h0000_0000, te});
        far(8'hC3, 1'h0, 7'h7F, 1'h0);
        wr(4'h0, 4'h2, 32'h0000_8000);
        settle();
        pins(8'h5A, 8'h80);
        wr(4'h8, 4'h1, 32'h0000_0000);
        settle();
        pins(8'h5A, 8'h00);
        wr(4'h0, 4'h1, 32'h0000_0080);
        settle();
        pins(8'h5A, 8'h80);
        $display("test transmitter finished");

        wr(4'h0, 4'h3, 32'h0000_0800);
        wr(4'h8, 4'h1, 32'h0000_0003);
        settle();
        rdc("fault", 4'hC, 32'h0000_0001);
        chk("mode_fault", 32'h0000_0001, {31'h0000_0000, flt});
        far(8'hCB, 1'h0, 7'h7F, 1'h0);
        settle();
        wr(4'hC, 4'h1, 32'h0000_0001);
        rdc("fault", 4'hC, 32'h0000_0000);
        $display("test fault finished");
        end_sim();
    end
endmodule

`default_nettype wire
